// file: design/serial_parameter_mapper.sv
/* Parameter access layer behind the serial port in text mode.
   Assumes a character engine hands over one checked message per req_valid_i pulse. */
// Operation
// - Link rate follows tag 198.
// - Group and unit address must match.
// - Version words are read-only, 16 bits.
// - Keypad version is zero without keypad.
// - Any host fault write gives 00C0; a hardware fault code in the same cycle wins.
// - Command 5555 enters, 4444 leaves configuration.
// - Command 7777 loads defaults without saving.
// - Command 0101 reloads saved, 0111 default setup.
// - State word codes zero to five.
// - Save command zero clears a failure.
// - Save command one starts a save.
// - Save progress: zero idle, one saving, two failed.
// - Tags below 936: add 360, base-36 pair.
// - Tags from 936: minus 936, base 26, lower then upper.
// - Legacy parameter numbers also select parameters.
// - Truth values 00/01, single digits accepted.
// - Bitstrings are 16-bit hex, zeros suppressible.
// - Integers travel as zero-suppressed decimal text.
// - Enumerations travel as hex, two digits at most.
// - Negative source tag marks a feedback link.
// - Decimal values must carry the point.
// - Characters: seven data bits, even parity, one stop.
// - Drive only answers, never initiates.
`timescale 1ns/1ps
`include "spm_map.svh"
module serial_parameter_mapper #(
    parameter logic [7:0] TEXT_MODE_CODE = 8'h01,
    parameter logic [15:0] IDENTITY = 16'hA5C3
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] port_mode_i,
    input wire logic [7:0] baud_rate_i,
    input wire logic [7:0] group_address_i,
    input wire logic [7:0] unit_address_i,
    input wire logic req_valid_i,
    input wire spm_pkg::access_req_t req_i,
    input wire logic [15:0] main_fw_version_i,
    input wire logic [15:0] keypad_fw_version_i,
    input wire logic keypad_present_i,
    input wire logic [15:0] option_box_fw_version_i,
    input wire logic fault_valid_i,
    input wire logic [15:0] fault_code_i,
    input wire logic boot_done_i,
    input wire logic product_ok_i,
    input wire logic config_ok_i,
    input wire logic restore_done_i,
    input wire logic save_done_i,
    input wire logic save_error_i,
    input wire logic [10:0] tag_cnv_i,
    output logic [15:0] mnem_o,
    output logic [7:0] link_rate_o,
    output spm_pkg::access_rsp_t rsp_o,
    output spm_pkg::param_req_t param_o,
    output logic config_mode_o,
    output logic load_saved_o,
    output logic load_default_o,
    output logic load_product_default_o,
    output logic save_start_o,
    output logic [15:0] major_state_o,
    output logic [15:0] save_progress_o
);
    typedef enum logic [1:0] {PH_IDLE = 2'h0, PH_PARSE = 2'h1, PH_APPLY = 2'h2} phase_t;
    typedef enum logic [3:0] {
        TG_IDENT = 4'h0, TG_VER0 = 4'h1, TG_VER1 = 4'h2, TG_VER2 = 4'h3, TG_FAULT = 4'h4,
        TG_CMD = 4'h5, TG_STATE = 4'h6, TG_SAVE = 4'h7, TG_SAVE_ST = 4'h8, TG_PARAM = 4'h9,
        TG_NONE = 4'hA
    } target_t;
    function automatic logic [4:0] hex_val(input logic [7:0] c);
        if (c >= `SPM_CH_ZERO && c <= `SPM_CH_NINE) begin
            return {1'b0, c[3:0]};
        end else if ((c >= `SPM_CH_LOWER_A && c <= `SPM_CH_LOWER_F) ||
                     (c >= `SPM_CH_UPPER_A && c <= `SPM_CH_UPPER_F)) begin
            return {1'b0, 4'(c[3:0] + 4'h9)};
        end
        return 5'h10;
    endfunction
    // Bit 6 flags a character outside 0-9 and a-z
    function automatic logic [6:0] b36_val(input logic [7:0] c);
        return (c >= `SPM_CH_ZERO && c <= `SPM_CH_NINE) ? {1'b0, 6'(c - `SPM_CH_ZERO)} :
               (c >= `SPM_CH_LOWER_A && c <= `SPM_CH_LOWER_Z) ?
               {1'b0, 6'(c - `SPM_CH_LOWER_A + 8'h0A)} : 7'h40;
    endfunction
    function automatic logic [7:0] b36_chr(input logic [5:0] v);
        return v >= `SPM_DIGIT_LIMIT ? 8'(`SPM_CH_LOWER_A + {2'h0, v} - 8'h0A) :
               8'(`SPM_CH_ZERO + {2'h0, v});
    endfunction
    phase_t phase_ff;
    target_t target_ff;
    spm_pkg::access_req_t req_ff;
    spm_pkg::major_state_t major_ff;
    spm_pkg::save_state_t save_ff;
    logic [10:0] tag_ff;
    logic [3:0] idx_ff, frac_ff, digits_ff;
    logic [31:0] acc_ff;
    logic legacy_ff, neg_ff, dot_ff, bad_ff;
    logic [15:0] fault_ff;
    target_t nxt_target;
    logic [10:0] nxt_tag, low_sum;
    logic nxt_legacy;
    logic [6:0] d1, d2;
    logic [4:0] h1, h2;
    always_comb begin
        nxt_target = TG_NONE;
        nxt_tag = 11'h000;
        nxt_legacy = 1'b0;
        d1 = b36_val(req_i.c1);
        d2 = b36_val(req_i.c2);
        h1 = hex_val(req_i.c1);
        h2 = hex_val(req_i.c2);
        low_sum = 11'(d1[5:0] * `SPM_LOW_RADIX + {5'h00, d2[5:0]});
        unique case ({req_i.c1, req_i.c2})
            `SPM_MN_IDENT: nxt_target = TG_IDENT;
            `SPM_MN_VER0: nxt_target = TG_VER0;
            `SPM_MN_VER1: nxt_target = TG_VER1;
            `SPM_MN_VER2: nxt_target = TG_VER2;
            `SPM_MN_FAULT: nxt_target = TG_FAULT;
            `SPM_MN_CMD: nxt_target = TG_CMD;
            `SPM_MN_STATE: nxt_target = TG_STATE;
            `SPM_MN_SAVE: nxt_target = TG_SAVE;
            `SPM_MN_SAVE_ST: nxt_target = TG_SAVE_ST;
            default: begin
                if (req_i.c1 >= `SPM_CH_LOWER_A && req_i.c1 <= `SPM_CH_LOWER_Z &&
                    req_i.c2 >= `SPM_CH_UPPER_A && req_i.c2 <= `SPM_CH_UPPER_Z) begin
                    nxt_target = TG_PARAM;
                    nxt_tag = 11'(`SPM_TAG_SPLIT + 11'(req_i.c1 - `SPM_CH_LOWER_A) *
                        `SPM_HIGH_RADIX + 11'(req_i.c2 - `SPM_CH_UPPER_A));
                end else if (!d1[6] && !d2[6] && low_sum >= `SPM_TAG_BIAS) begin
                    nxt_target = TG_PARAM;
                    nxt_tag = low_sum - `SPM_TAG_BIAS;
                end else if (!h1[4] && !h2[4]) begin
                    // Sums under the bias map to no tag, so these stay unambiguous
                    nxt_target = TG_PARAM;
                    nxt_legacy = 1'b1;
                    nxt_tag = {3'h0, h1[3:0], h2[3:0]};
                end
            end
        endcase
    end
    logic addressed, accept, rd_bad;
    logic [15:0] rd_word;
    assign addressed = port_mode_i == TEXT_MODE_CODE &&
                       req_i.group == group_address_i &&
                       req_i.unit == unit_address_i && req_i.frame_ok;
    assign accept = req_valid_i && phase_ff == PH_IDLE && addressed;
    always_comb begin
        rd_word = 16'h0000;
        rd_bad = 1'b0;
        unique case (nxt_target)
            TG_IDENT: rd_word = IDENTITY; // Arbitrary value
            TG_VER0: rd_word = main_fw_version_i;
            TG_VER1: rd_word = keypad_present_i ? keypad_fw_version_i : 16'h0000;
            TG_VER2: rd_word = option_box_fw_version_i;
            TG_FAULT: rd_word = fault_ff;
            TG_STATE: rd_word = {13'h0000, major_ff};
            TG_SAVE_ST: rd_word = {14'h0000, save_ff};
            TG_PARAM: rd_word = 16'h0000;
            TG_CMD, TG_SAVE, TG_NONE: rd_bad = 1'b1;
        endcase
    end
    logic [95:0] text_sh;
    logic [7:0] ch;
    logic [4:0] ch_hex;
    logic is_dec, last;
    assign text_sh = req_ff.text << {idx_ff, 3'h0};
    assign ch = text_sh[95:88];
    assign ch_hex = hex_val(ch);
    assign is_dec = target_ff == TG_PARAM &&
                    (req_ff.vtype == spm_pkg::VT_INT || req_ff.vtype == spm_pkg::VT_TAG);
    assign last = idx_ff == 4'(req_ff.len - 4'h1);
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_ff <= PH_IDLE;
            target_ff <= TG_NONE;
            req_ff <= '0;
            tag_ff <= 11'h000;
            legacy_ff <= 1'b0;
        end else begin
            unique case (phase_ff)
                PH_IDLE: begin
                    if (accept && req_i.write) begin
                        phase_ff <= PH_PARSE;
                        target_ff <= nxt_target;
                        req_ff <= req_i;
                        tag_ff <= nxt_tag;
                        legacy_ff <= nxt_legacy;
                    end
                end
                PH_PARSE: begin
                    if (last || req_ff.len == 4'h0 || req_ff.len > `SPM_TEXT_MAX) begin
                        phase_ff <= PH_APPLY;
                    end
                end
                PH_APPLY: phase_ff <= PH_IDLE;
                default: phase_ff <= PH_IDLE;
            endcase
        end
    end
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            idx_ff <= 4'h0;
            acc_ff <= 32'h0000_0000;
            neg_ff <= 1'b0;
            dot_ff <= 1'b0;
            frac_ff <= 4'h0;
            digits_ff <= 4'h0;
            bad_ff <= 1'b0;
        end else if (accept) begin
            idx_ff <= 4'h0;
            acc_ff <= 32'h0000_0000;
            neg_ff <= 1'b0;
            dot_ff <= 1'b0;
            frac_ff <= 4'h0;
            digits_ff <= 4'h0;
            bad_ff <= req_i.len == 4'h0 || req_i.len > `SPM_TEXT_MAX;
        end else if (phase_ff == PH_PARSE) begin
            idx_ff <= 4'(idx_ff + 4'h1);
            if (is_dec) begin
                // No overflow check: over-long magnitudes wrap at 32 bits
                if (ch == `SPM_CH_MINUS && idx_ff == 4'h0) begin
                    neg_ff <= 1'b1;
                end else if (ch == `SPM_CH_POINT && !dot_ff) begin
                    dot_ff <= 1'b1;
                end else if (ch >= `SPM_CH_ZERO && ch <= `SPM_CH_NINE) begin
                    acc_ff <= (acc_ff << 3) + (acc_ff << 1) + {28'h0, ch[3:0]};
                    digits_ff <= 4'(digits_ff + 4'h1);
                    if (dot_ff) begin
                        frac_ff <= 4'(frac_ff + 4'h1);
                    end
                end else begin
                    bad_ff <= 1'b1;
                end
            end else if (ch_hex[4]) begin
                bad_ff <= 1'b1;
            end else begin
                acc_ff <= {acc_ff[27:0], ch_hex[3:0]};
            end
        end
    end
    logic fmt_ok, wr_ok;
    always_comb begin
        fmt_ok = 1'b0;
        if (target_ff != TG_PARAM) begin
            fmt_ok = req_ff.len <= 4'h4;
        end else if (is_dec) begin
            fmt_ok = dot_ff && digits_ff != 4'h0;
        end else begin
            unique case (req_ff.vtype)
                spm_pkg::VT_TRUTH_VALUE: fmt_ok = req_ff.len <= 4'h2 && acc_ff <= 32'h1;
                spm_pkg::VT_WORD: fmt_ok = req_ff.len <= 4'h4;
                spm_pkg::VT_ENUM: fmt_ok = req_ff.len <= 4'h2;
                default: fmt_ok = 1'b0;
            endcase
        end
    end
    assign wr_ok = phase_ff == PH_APPLY && fmt_ok && !bad_ff;
    logic cmd_go, save_go, wr_refused;
    logic [15:0] wr_word;
    assign wr_word = acc_ff[15:0];
    assign cmd_go = wr_ok && target_ff == TG_CMD && major_ff != spm_pkg::MS_INIT;
    assign save_go = wr_ok && target_ff == TG_SAVE;
    assign wr_refused = target_ff inside {TG_IDENT, TG_VER0, TG_VER1, TG_VER2,
                                          TG_STATE, TG_SAVE_ST, TG_NONE};
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rsp_o <= '0;
        end else if (accept && !req_i.write) begin
            rsp_o <= '{ack: 1'b1, err: rd_bad, word: rd_word};
        end else if (phase_ff == PH_APPLY) begin
            rsp_o <= '{ack: 1'b1, err: !wr_ok || wr_refused, word: 16'h0000};
        end else begin
            rsp_o <= '{ack: 1'b0, err: 1'b0, word: rsp_o.word};
        end
    end
    // Generic parameters go to the drive's parameter store
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            param_o <= '0;
        end else if (accept && !req_i.write && nxt_target == TG_PARAM) begin
            param_o <= '{1'b1, nxt_legacy, nxt_tag, 1'b0, 1'b0, 1'b0, 4'h0, 32'h0};
        end else if (wr_ok && target_ff == TG_PARAM) begin
            param_o <= '{valid: 1'b1, legacy: legacy_ff, tag: tag_ff, write: 1'b1,
                         negative: neg_ff,
                         feedback: neg_ff && req_ff.vtype == spm_pkg::VT_TAG,
                         frac: frac_ff, value: acc_ff};
        end else begin
            param_o.valid <= 1'b0;
        end
    end
    // Hardware fault beats a same-cycle host write
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fault_ff <= `SPM_FAULT_RESET;
        end else if (fault_valid_i) begin
            fault_ff <= fault_code_i;
        end else if (wr_ok && target_ff == TG_FAULT) begin
            fault_ff <= `SPM_FAULT_HOST_WRITE;
        end
    end
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            major_ff <= spm_pkg::MS_INIT;
            load_saved_o <= 1'b0;
            load_default_o <= 1'b0;
            load_product_default_o <= 1'b0;
        end else begin
            load_saved_o <= 1'b0;
            load_default_o <= 1'b0;
            load_product_default_o <= 1'b0;
            if (major_ff == spm_pkg::MS_INIT) begin
                if (boot_done_i) begin
                    major_ff <= !product_ok_i ? spm_pkg::MS_BAD_ALL :
                                !config_ok_i ? spm_pkg::MS_BAD_CFG : spm_pkg::MS_NORMAL;
                end
            end else if (cmd_go && wr_word == `SPM_CMD_RESET) begin
                // Defaults are loaded but never written to storage here
                major_ff <= spm_pkg::MS_RESTORE;
                load_product_default_o <= 1'b1;
            end else if (cmd_go && wr_word == `SPM_CMD_LOAD_SAVED) begin
                major_ff <= spm_pkg::MS_RESTORE;
                load_saved_o <= 1'b1;
            end else if (cmd_go && wr_word == `SPM_CMD_LOAD_DEFAULT) begin
                major_ff <= spm_pkg::MS_RESTORE;
                load_default_o <= 1'b1;
            end else if (cmd_go && wr_word == `SPM_CMD_ENTER_CFG) begin
                major_ff <= spm_pkg::MS_RECONFIG;
            end else if (cmd_go && wr_word == `SPM_CMD_EXIT_CFG &&
                         major_ff == spm_pkg::MS_RECONFIG) begin
                major_ff <= spm_pkg::MS_NORMAL;
            end else if (major_ff == spm_pkg::MS_RESTORE && restore_done_i) begin
                major_ff <= spm_pkg::MS_NORMAL;
            end
            // Any other command code falls through untouched
        end
    end
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            save_ff <= spm_pkg::SV_IDLE;
            save_start_o <= 1'b0;
        end else begin
            save_start_o <= 1'b0;
            unique case (save_ff)
                spm_pkg::SV_IDLE: begin
                    if (save_go && wr_word == `SPM_SAVE_START) begin
                        save_ff <= spm_pkg::SV_SAVING;
                        save_start_o <= 1'b1;
                    end
                end
                spm_pkg::SV_SAVING: begin
                    if (save_error_i) begin
                        save_ff <= spm_pkg::SV_FAILED;
                    end else if (save_done_i) begin
                        save_ff <= spm_pkg::SV_IDLE;
                    end
                end
                spm_pkg::SV_FAILED: begin
                    if (save_go && wr_word == `SPM_SAVE_CLEAR) begin
                        save_ff <= spm_pkg::SV_IDLE;
                    end
                end
                default: save_ff <= spm_pkg::SV_IDLE;
            endcase
        end
    end
    logic [10:0] low_tag, high_tag;
    assign low_tag = 11'(tag_cnv_i + `SPM_TAG_BIAS);
    assign high_tag = 11'(tag_cnv_i - `SPM_TAG_SPLIT);
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mnem_o <= 16'h0000;
        end else if (tag_cnv_i < `SPM_TAG_SPLIT) begin
            mnem_o <= {b36_chr(6'(low_tag / `SPM_LOW_RADIX)),
                       b36_chr(6'(low_tag % `SPM_LOW_RADIX))};
        end else begin
            mnem_o <= {8'(`SPM_CH_LOWER_A + 8'(high_tag / `SPM_HIGH_RADIX)),
                       8'(`SPM_CH_UPPER_A + 8'(high_tag % `SPM_HIGH_RADIX))};
        end
    end
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            link_rate_o <= 8'h00;
            config_mode_o <= 1'b0;
            major_state_o <= 16'h0000;
            save_progress_o <= 16'h0000;
        end else begin
            link_rate_o <= baud_rate_i;
            config_mode_o <= major_ff == spm_pkg::MS_RECONFIG;
            major_state_o <= {13'h0000, major_ff};
            save_progress_o <= {14'h0000, save_ff};
        end
    end
endmodule

// file: pkg/spm_map.svh
/*
 * Codes and character values of the parameter mapper.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef SPM_MAP_SVH
`define SPM_MAP_SVH

`define SPM_TAG_SPLIT 11'h3A8
`define SPM_TAG_BIAS 11'h168
`define SPM_LOW_RADIX 11'h024
`define SPM_HIGH_RADIX 11'h01A
`define SPM_DIGIT_LIMIT 6'h0A
`define SPM_TEXT_MAX 4'hC

`define SPM_CMD_RESET 16'h7777
`define SPM_CMD_LOAD_SAVED 16'h0101
`define SPM_CMD_LOAD_DEFAULT 16'h0111
`define SPM_CMD_EXIT_CFG 16'h4444
`define SPM_CMD_ENTER_CFG 16'h5555
`define SPM_SAVE_CLEAR 16'h0000
`define SPM_SAVE_START 16'h0001

`define SPM_FAULT_RESET 16'h0000
`define SPM_FAULT_HOST_WRITE 16'h00C0

`define SPM_MN_IDENT 16'h4949
`define SPM_MN_VER0 16'h5630
`define SPM_MN_VER1 16'h5631
`define SPM_MN_VER2 16'h5632
`define SPM_MN_FAULT 16'h4545
`define SPM_MN_CMD 16'h2131
`define SPM_MN_STATE 16'h2132
`define SPM_MN_SAVE 16'h2133
`define SPM_MN_SAVE_ST 16'h2134

`define SPM_CH_MINUS 8'h2D
`define SPM_CH_POINT 8'h2E
`define SPM_CH_ZERO 8'h30
`define SPM_CH_NINE 8'h39
`define SPM_CH_LOWER_A 8'h61
`define SPM_CH_LOWER_F 8'h66
`define SPM_CH_LOWER_Z 8'h7A
`define SPM_CH_UPPER_A 8'h41
`define SPM_CH_UPPER_F 8'h46
`define SPM_CH_UPPER_Z 8'h5A

`endif

// file: pkg/spm_pkg.sv
/*
 * Types of the serial parameter mapper.
 * Assumes framing and checksums are handled by a character engine outside.
 */
package spm_pkg;
    typedef enum logic [2:0] {
        VT_TRUTH_VALUE = 3'h0,
        VT_WORD = 3'h1,
        VT_INT = 3'h2,
        VT_ENUM = 3'h3,
        VT_TAG = 3'h4
    } val_type_t;

    typedef enum logic [2:0] {
        MS_INIT = 3'h0,
        MS_BAD_ALL = 3'h1,
        MS_BAD_CFG = 3'h2,
        MS_RESTORE = 3'h3,
        MS_RECONFIG = 3'h4,
        MS_NORMAL = 3'h5
    } major_state_t;

    typedef enum logic [1:0] {
        SV_IDLE = 2'h0,
        SV_SAVING = 2'h1,
        SV_FAILED = 2'h2
    } save_state_t;

    typedef struct packed {
        logic [7:0] group;
        logic [7:0] unit;
        logic frame_ok;
        logic [7:0] c1;
        logic [7:0] c2;
        logic write;
        val_type_t vtype;
        logic [3:0] len;
        logic [95:0] text;
    } access_req_t;

    typedef struct packed {
        logic ack;
        logic err;
        logic [15:0] word;
    } access_rsp_t;

    typedef struct packed {
        logic valid;
        logic legacy;
        logic [10:0] tag;
        logic write;
        logic negative;
        logic feedback;
        logic [3:0] frac;
        logic [31:0] value;
    } param_req_t;
endpackage

// file: verification/spm_assertions.sv
/* Output checker of the parameter mapper.
   Assumes binding onto serial_parameter_mapper. */
`timescale 1ns/1ps
module spm_assertions (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] baud_rate_i,
    input wire logic [7:0] link_rate_o,
    input wire spm_pkg::param_req_t param_o,
    input wire logic config_mode_o,
    input wire logic load_saved_o,
    input wire logic load_default_o,
    input wire logic load_product_default_o,
    input wire logic save_start_o,
    input wire logic [15:0] major_state_o,
    input wire logic [15:0] save_progress_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    rate_copy_a: assert property (!$past(rst_i) |-> link_rate_o == $past(baud_rate_i))
        else $error("link rate differs");
    cfg_mode_a: assert property (config_mode_o == (major_state_o == 16'h0004))
        else $error("config mode flag off");
    state_range_a: assert property (major_state_o <= 16'h0005)
        else $error("state code out of range");
    save_range_a: assert property (save_progress_o <= 16'h0002)
        else $error("save code out of range");
    save_go_a: assert property (save_start_o |=> save_progress_o == 16'h0001)
        else $error("save not in progress");
    start_pulse_a: assert property (save_start_o |=> !save_start_o)
        else $error("save start too long");
    fail_hold_a: assert property (save_progress_o == 16'h0002 |=> save_progress_o != 16'h0001)
        else $error("failed save left wrongly");
    reset_cmd_a: assert property (load_product_default_o |-> ##[0:1] major_state_o == 16'h0003)
        else $error("reset command not restoring");
    reload_a: assert property (load_saved_o || load_default_o |-> ##[0:1] major_state_o == 16'h0003)
        else $error("reload not restoring");
    feedback_neg_a: assert property (param_o.feedback |-> param_o.negative)
        else $error("feedback without sign");
    cover property (save_start_o);
    cover property (config_mode_o);
    cover property (load_product_default_o);
endmodule

bind serial_parameter_mapper spm_assertions chk (.core_clk_i, .rst_i, .baud_rate_i, .link_rate_o,
    .param_o, .config_mode_o, .load_saved_o, .load_default_o, .load_product_default_o,
    .save_start_o, .major_state_o, .save_progress_o);

// file: verification/spm_host.sv
/* Supervisory host model: one message per send call.
   Assumes calls start just after a rising clock edge. */
`timescale 1ns/1ps
module spm_host #(
    parameter logic [7:0] GRP = 8'h31,
    parameter logic [7:0] UNT = 8'h32
) (
    input wire logic core_clk_i,
    output logic req_valid_o,
    output spm_pkg::access_req_t req_o
);
    initial begin
        req_valid_o = 1'b0;
        req_o = '0;
    end
    // Only the host ever opens an exchange
    task automatic send(input logic [15:0] mn, input logic wr, input spm_pkg::val_type_t vt,
                        input logic [3:0] len, input logic [95:0] txt);
        req_o = {GRP, UNT, 1'b1, mn, wr, vt, len, txt};
        req_valid_o = 1'b1;
        @(posedge core_clk_i);
        #1;
        req_valid_o = 1'b0;
        // Stale fields flip so nobody trusts them
        req_o = ~req_o;
    endtask
endmodule

// file: verification/testbench.sv
/* Self-checking bench of the parameter mapper.
   Assumes host model and checker are compiled first. */
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [15:0] mn;
        logic wr;
        logic [7:0] c;
        logic err;
        logic [15:0] word;
    } row_t;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] baud = 8'h5A;
    logic kp = 1'b1, fv = 1'b0, rdone = 1'b0, sdone = 1'b0, serr = 1'b0, cok = 1'b1, pok = 1'b1;
    logic [15:0] vm = 16'hFFFF, vk = 16'h8001, vo = 16'h0000, fc = 16'hBEEF;
    logic [10:0] tag = 11'h000;
    logic req_valid, cfg, ls, ld, lpd, ss;
    spm_pkg::access_req_t req;
    logic [15:0] mnem, mst, sprog;
    logic [7:0] rate;
    spm_pkg::access_rsp_t rsp;
    spm_pkg::param_req_t prm, p;
    int failures = 0, n_compared = 0;
    int tags [6] = '{0, 130, 198, 935, 936, 1611};
    logic [15:0] cmds [6] = '{16'h5555, 16'h4444, 16'h1234, 16'h7777, 16'h0101, 16'h0111};
    logic [15:0] ste [6] = '{16'h4, 16'h5, 16'h5, 16'h3, 16'h3, 16'h3};
    row_t rows [11] = '{'{16'h4949, 1'h0, 8'h0, 1'h0, 16'h1234},
        '{16'h5630, 1'h0, 8'h0, 1'h0, 16'hFFFF}, '{16'h5631, 1'h0, 8'h0, 1'h0, 16'h8001},
        '{16'h5632, 1'h0, 8'h0, 1'h0, 16'h0}, '{16'h2131, 1'h0, 8'h0, 1'h1, 16'h0},
        '{16'h2133, 1'h0, 8'h0, 1'h1, 16'h0}, '{16'h5630, 1'h1, 8'h31, 1'h1, 16'h0},
        '{16'h4545, 1'h1, 8'h35, 1'h0, 16'h0}, '{16'h4545, 1'h0, 8'h0, 1'h0, 16'h00C0},
        '{16'h2134, 1'h0, 8'h0, 1'h0, 16'h0}, '{16'h2132, 1'h0, 8'h0, 1'h0, 16'h5}};
    always #2 core_clk_i = ~core_clk_i;
    spm_host host (.core_clk_i, .req_valid_o(req_valid), .req_o(req));
    serial_parameter_mapper #(.IDENTITY(16'h1234)) dut (.core_clk_i, .rst_i,
        .port_mode_i(8'h01), .baud_rate_i(baud), .group_address_i(8'h31),
        .unit_address_i(8'h32), .req_valid_i(req_valid), .req_i(req), .main_fw_version_i(vm),
        .keypad_fw_version_i(vk), .keypad_present_i(kp), .option_box_fw_version_i(vo),
        .fault_valid_i(fv), .fault_code_i(fc), .boot_done_i(1'b1), .product_ok_i(pok),
        .config_ok_i(cok), .restore_done_i(rdone), .save_done_i(sdone), .save_error_i(serr),
        .tag_cnv_i(tag), .mnem_o(mnem), .link_rate_o(rate), .rsp_o(rsp), .param_o(prm),
        .config_mode_o(cfg), .load_saved_o(ls), .load_default_o(ld),
        .load_product_default_o(lpd), .save_start_o(ss), .major_state_o(mst),
        .save_progress_o(sprog));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic acc(input logic [15:0] mn, input logic wr, input spm_pkg::val_type_t vt,
                       input logic [3:0] len, input logic [95:0] txt, input logic err);
        int i;
        host.send(mn, wr, vt, len, txt);
        for (i = 0; i < 20 && rsp.ack !== 1'b1; i++) cyc(1);
        p = prm;
        chk(i < 20, 1'b1);
        chk(rsp.err, err);
    endtask
    task automatic sv(input logic [7:0] c, input logic [15:0] e);
        acc(16'h2133, 1'b1, spm_pkg::VT_WORD, 4'h1, {c, 88'h0}, 1'b0);
        cyc(2);
        chk(sprog, e);
    endtask
    function automatic logic [7:0] ch(input int v);
        return v > 9 ? 8'(8'h61 + v - 10) : 8'(8'h30 + v);
    endfunction
    task automatic final_report();
        if (failures == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        final_report();
    end
    initial begin
        cyc(16);
        chk({mst, sprog}, 32'h0);
        rst_i = 1'b0;
        cyc(4);
        foreach (rows[k]) begin
            acc(rows[k].mn, rows[k].wr, spm_pkg::VT_WORD, 4'h1, {rows[k].c, 88'h0}, rows[k].err);
            if (!rows[k].wr && !rows[k].err) chk(rsp.word, rows[k].word);
        end
        kp = 1'b0;
        fv = 1'b1;
        cyc(1);
        fv = 1'b0;
        acc(16'h5631, 1'b0, spm_pkg::VT_WORD, 4'h1, 96'h0, 1'b0);
        chk(rsp.word, 16'h0);
        acc(16'h4545, 1'b0, spm_pkg::VT_WORD, 4'h1, 96'h0, 1'b0);
        chk(rsp.word, fc);
        foreach (cmds[k]) begin
            acc(16'h2131, 1'b1, spm_pkg::VT_WORD, 4'h4, {4'h3, cmds[k][15:12], 4'h3,
                cmds[k][11:8], 4'h3, cmds[k][7:4], 4'h3, cmds[k][3:0], 64'h0}, 1'b0);
            cyc(2);
            chk(mst, ste[k]);
            chk(cfg, ste[k] == 16'h4);
            rdone = 1'b1;
            cyc(1);
            rdone = 1'b0;
        end
        sv(8'h31, 16'h1);
        serr = 1'b1;
        cyc(1);
        serr = 1'b0;
        sv(8'h31, 16'h2);
        sv(8'h30, 16'h0);
        sv(8'h31, 16'h1);
        sdone = 1'b1;
        cyc(3);
        sdone = 1'b0;
        chk(sprog, 16'h0);
        foreach (tags[k]) begin
            tag = 11'(tags[k]);
            cyc(2);
            if (tags[k] < 936) chk(mnem, {ch((tags[k] + 360) / 36), ch((tags[k] + 360) % 36)});
            else chk(mnem, {8'(8'h61 + (tags[k] - 936) / 26), 8'(8'h41 + (tags[k] - 936) % 26)});
        end
        acc(16'h6141, 1'b1, spm_pkg::VT_INT, 4'h5, {"-12.5", 56'h0}, 1'b0);
        chk({p.valid, p.negative, p.frac, p.tag}, {1'b1, 1'b1, 4'h1, 11'h3A8});
        chk(p.value, 32'h7D);
        acc(16'h6141, 1'b1, spm_pkg::VT_TAG, 4'h3, {"-7.", 72'h0}, 1'b0);
        chk(p.feedback, 1'b1);
        acc(16'h6141, 1'b1, spm_pkg::VT_INT, 4'h2, {"12", 80'h0}, 1'b1);
        acc(16'h6141, 1'b1, spm_pkg::VT_TRUTH_VALUE, 4'h1, {"1", 88'h0}, 1'b0);
        chk(p.value, 32'h1);
        acc(16'h6141, 1'b1, spm_pkg::VT_WORD, 4'h4, {"FFFF", 64'h0}, 1'b0);
        chk(p.value, 32'hFFFF);
        acc(16'h6141, 1'b1, spm_pkg::VT_ENUM, 4'h1, {"0", 88'h0}, 1'b0);
        chk(p.value, 32'h0);
        acc(16'h3237, 1'b0, spm_pkg::VT_WORD, 4'h1, 96'h0, 1'b0);
        chk({p.legacy, p.tag}, {1'b1, 11'h027});
        baud = 8'hA5;
        cyc(2);
        chk(rate, 8'hA5);
        rst_i = 1'b1;
        cyc(1);
        chk(mst, 16'h0);
        pok = 1'b0;
        rst_i = 1'b0;
        cyc(4);
        chk(mst, 16'h1);
        final_report();
    end
endmodule
